//--- verilog/pdm_pkg.sv
// Shared constants for the PDM pattern-control source and device ends
package pdm_pkg;
    // ==================== Clocking ====================
    localparam int MCLK_KHZ = 250000;
    // Band edges of the bit clock, in kHz
    localparam int LO_BAND_MIN_KHZ = 1840;
    localparam int LO_BAND_MAX_KHZ = 3230;
    localparam int HI_BAND_MIN_KHZ = 3680;
    localparam int HI_BAND_MAX_KHZ = 6460;
    // Bit clock rates the source makes, inside each band
    localparam int SRC_LO_KHZ = 3125;
    localparam int SRC_HI_KHZ = 6250;
    localparam int HALF_LO_CYC = MCLK_KHZ / (2 * SRC_LO_KHZ);
    localparam int HALF_HI_CYC = MCLK_KHZ / (2 * SRC_HI_KHZ);
    // No bit clock edge for this long means the clock is gone
    localparam int CLK_LOSS_NS = 2000;
    localparam int CLK_LOSS_CYC = (CLK_LOSS_NS * MCLK_KHZ + 999999) / 1000000;
    // Start-up time after leaving power-down
    localparam int STARTUP_NS = 20000;
    localparam int STARTUP_CYC = (STARTUP_NS * MCLK_KHZ + 999999) / 1000000;

    // ==================== Patterns ====================
    localparam logic [7:0] PAT_STOP = 8'hac;
    localparam logic [7:0] PAT_GAIN_5V = 8'hd8;
    localparam logic [7:0] PAT_GAIN_3V6 = 8'hd4;
    localparam logic [7:0] PAT_GAIN_2V5 = 8'hd2;
    localparam logic [7:0] PAT_RATE_FLIP = 8'hd1;
    localparam logic [7:0] PAT_LOW_EMI = 8'he1;
    localparam logic [7:0] PAT_HALF_PULSE = 8'he2;
    localparam logic [7:0] PAT_SPECIAL_32K = 8'he4;
    localparam int PAT_MIN_REPS = 128;
    localparam int PAT_BITS = 8;

    // ==================== Strap and settings ====================
    // Strap bit 1: pulled to supply (64x); bit 0: through resistor (5 V gain)
    localparam int STRAP_UP_BIT = 1;
    localparam int STRAP_RES_BIT = 0;
    localparam int DECIM_64 = 64;
    localparam int DECIM_128 = 128;
    typedef enum logic [1:0] {
        GAIN_5V = 2'b00,
        GAIN_3V6 = 2'b01,
        GAIN_2V5 = 2'b10
    } gain_t;
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN = 2'b01,
        ST_STANDBY = 2'b10,
        ST_FULL_PD = 2'b11
    } dev_state_t;

    // ==================== Source command registers ====================
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_AUDIO = 4'h4;
    localparam logic [3:0] REG_PATTERN = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hc;
    localparam int CTRL_CLK_EN = 0;
    localparam int CTRL_HI_BAND = 1;
    localparam int CTRL_RIGHT = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] AUDIO_RESET = 8'haa;
endpackage : pdm_pkg

//--- verilog/pdm_if.sv
// PDM link between the source modulator and the amplifier front end
`timescale 1ns/1ns
interface pdm_if;
    logic pdm_clk;
    logic pdm_data_in;
    modport src (output pdm_clk, output pdm_data_in);
    modport dev (input pdm_clk, input pdm_data_in);
endinterface : pdm_if

//--- verilog/pdm_pattern_device.sv
// Amplifier front end: strap decode, pattern control, smart power-down
// Contract
// (RULE1) Source bit clock stays inside one band
// (RULE2) Source keeps clock synchronous with data
// (RULE3) Strap latched once at power-stage supply-up
// (RULE4) Repeated stop byte enters standby
// (RULE5) Clock stopped in standby gives full power-down
// (RULE6) Clock back plus non-stop byte resumes
// (RULE7) Low supply holds logic reset, outputs off
// (RULE8) Strap decodes to rate and gain
// (RULE9) Separate decimation for 64x and 128x
// (RULE10) Prefer 64x rate unless source limits
// (RULE11) In-band 8-bit repeating patterns are commands
// (RULE12) Act only after 128 consecutive repeats
// (RULE13) Mute output while a pattern is seen
// (RULE14) Clock-loss power-down reverts pattern settings
// (RULE15) Stop pattern powers down all but interface
// (RULE16) Gain patterns override strap gain
// (RULE17) Rate-flip pattern inverts strap rate
// (RULE18) EMI pattern selects low-emission modulation
// (RULE19) Half-pulse and special 32 kHz patterns
// (RULE20) Three-level output, zero when idle
// (RULE21) Channel select picks left or right
// (RULE22) Source holds data stable around sample edge
// (RULE23) Left on rising edge, right on falling
// (RULE24) Byte-periodic match count, cleared on mismatch
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
module pdm_pattern_device #(
    parameter int STARTUP_CYCLES = pdm_pkg::STARTUP_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // PDM link
    pdm_if.dev link,
    // Static pins and supervisor levels
    input wire logic [1:0] gain_rate_strap,
    input wire logic channel_select,
    input wire logic power_stage_supply,
    input wire logic logic_supply,
    input wire logic smart_pd_en,
    // Status and settings
    output logic amp_on,
    output logic standby,
    output logic full_pd,
    output logic mute,
    output logic rate_128x,
    output pdm_pkg::gain_t gain_sel,
    output logic low_emi,
    output logic half_pulse,
    output logic special_32k,
    // Decimated audio and output stage
    output logic [7:0] pcm_sample,
    output logic pcm_valid,
    output logic out_pos,
    output logic out_neg
);
    import pdm_pkg::*;

    initial begin
        if (STARTUP_CYCLES < 1 || STARTUP_CYCLES > 65535) begin
            $error("STARTUP_CYCLES out of range");
        end
    end

    localparam logic [10:0] RUN_NEED = 11'((PAT_MIN_REPS - 1) * PAT_BITS);
    localparam logic [10:0] RUN_SAT = 11'h7ff;
    localparam logic [10:0] LOSS_LIM = 11'(CLK_LOSS_CYC);
    localparam logic [15:0] START_LIM = 16'(STARTUP_CYCLES - 1);
    localparam logic [6:0] DEC64_LAST = 7'(DECIM_64 - 1);
    localparam logic [6:0] DEC128_LAST = 7'(DECIM_128 - 1);

    function automatic logic stop_rotation(input logic [7:0] w);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            hit = hit | (w == ((PAT_STOP << i) | (PAT_STOP >> (8 - i))));
        end
        return hit;
    endfunction : stop_rotation

    // ==================== Input synchronisers ====================
    logic [6:0] sync1_r;
    logic [6:0] sync2_r;
    logic clk_d_r;
    wire logic [6:0] raw_in = {logic_supply, power_stage_supply, gain_rate_strap,
                               channel_select, link.pdm_data_in, link.pdm_clk};
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_r <= 7'h00;
            sync2_r <= 7'h00;
            clk_d_r <= 1'b0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            clk_d_r <= sync2_r[0];
        end
    end
    wire logic pclk_s = sync2_r[0];
    wire logic pdm_data_in_s = sync2_r[1];
    wire logic chsel_s = sync2_r[2];
    wire logic [1:0] strap_s = sync2_r[4:3];
    wire logic sup_ok = sync2_r[5] & sync2_r[6]; // [RULE7]
    wire logic rise = pclk_s & ~clk_d_r;
    wire logic fall = ~pclk_s & clk_d_r;
    // Data is taken on the edge opposite to where the partner changes it
    wire logic take = chsel_s ? fall : rise; // [RULE21] [RULE23] [RULE22]

    // ==================== Strap capture ====================
    logic strap_taken_r;
    logic [1:0] strap_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            strap_taken_r <= 1'b0;
            strap_r <= 2'b00;
        end else if (!sup_ok) begin
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1; // [RULE3]
            strap_r <= strap_s;
        end
    end
    wire logic strap_128x = ~strap_r[STRAP_UP_BIT]; // [RULE8]
    wire gain_t strap_gain = strap_r[STRAP_RES_BIT] ? GAIN_5V : GAIN_3V6;

    // ==================== Pattern detector ====================
    logic [7:0] hist_r;
    logic [10:0] run_r;
    logic take_d_r;
    logic acted_r;
    logic seen_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hist_r <= 8'h00;
            run_r <= 11'h000;
            take_d_r <= 1'b0;
        end else begin
            take_d_r <= take;
            if (take) begin
                hist_r <= {hist_r[6:0], pdm_data_in_s}; // [RULE11]
                if (pdm_data_in_s != hist_r[7]) begin
                    run_r <= 11'h000; // [RULE24]
                end else if (run_r != RUN_SAT) begin
                    run_r <= run_r + 11'h001;
                end
            end
        end
    end
    wire logic hit_stop = hist_r == PAT_STOP;
    wire logic hit_g5 = hist_r == PAT_GAIN_5V;
    wire logic hit_g36 = hist_r == PAT_GAIN_3V6;
    wire logic hit_g25 = hist_r == PAT_GAIN_2V5;
    wire logic hit_flip = hist_r == PAT_RATE_FLIP;
    wire logic hit_emi = hist_r == PAT_LOW_EMI;
    wire logic hit_half = hist_r == PAT_HALF_PULSE;
    wire logic hit_32k = hist_r == PAT_SPECIAL_32K;
    wire logic hit_any = hit_stop | hit_g5 | hit_g36 | hit_g25 | hit_flip | hit_emi
                         | hit_half | hit_32k;
    wire logic act = take_d_r & hit_any & ~acted_r & (run_r >= RUN_NEED); // [RULE12]
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            acted_r <= 1'b0;
            seen_r <= 1'b0;
        end else if (run_r == 11'h000) begin
            acted_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            acted_r <= acted_r | act;
            seen_r <= seen_r | (take_d_r & hit_any & (run_r >= 11'(PAT_BITS))); // [RULE13]
        end
    end

    // ==================== Power state ====================
    dev_state_t state_r;
    logic [10:0] idle_r;
    logic [15:0] start_r;
    logic [3:0] bits_r;
    wire logic clk_lost = idle_r == LOSS_LIM;
    wire logic non_stop = take_d_r & (bits_r >= 4'd8) & ~stop_rotation(hist_r); // [RULE6]
    wire logic lost_pd = clk_lost & ((state_r == ST_STANDBY) | smart_pd_en); // [RULE5]
    dev_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_STARTUP: if (start_r == START_LIM) state_nxt = ST_RUN;
            ST_RUN: if (act & hit_stop) state_nxt = ST_STANDBY; // [RULE4] [RULE15]
            ST_STANDBY: if (non_stop) state_nxt = ST_STARTUP;
            ST_FULL_PD: if (non_stop) state_nxt = ST_STARTUP;
        endcase
        if (lost_pd) state_nxt = ST_FULL_PD;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_STARTUP;
            idle_r <= 11'h000;
            start_r <= 16'h0000;
            bits_r <= 4'h0;
        end else if (!sup_ok) begin
            state_r <= ST_STARTUP; // [RULE7]
            start_r <= 16'h0000;
            bits_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            idle_r <= (rise | fall) ? 11'h000 : (clk_lost ? idle_r : idle_r + 11'h001);
            start_r <= (state_r == ST_STARTUP) ? start_r + 16'h0001 : 16'h0000;
            if (state_nxt != state_r) begin
                bits_r <= 4'h0;
            end else if (take && bits_r != 4'd8) begin
                bits_r <= bits_r + 4'h1;
            end
        end
    end

    // ==================== Pattern settings ====================
    logic gain_ovr_r;
    gain_t gain_val_r;
    logic flip_r;
    logic emi_r;
    logic half_r;
    logic sp32_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gain_ovr_r <= 1'b0;
            gain_val_r <= GAIN_5V;
            {flip_r, emi_r, half_r, sp32_r} <= 4'h0;
        end else if (!sup_ok || lost_pd) begin
            gain_ovr_r <= 1'b0; // [RULE14]
            {flip_r, emi_r, half_r, sp32_r} <= 4'h0;
        end else if (act) begin
            if (hit_g5 | hit_g36 | hit_g25) begin
                gain_ovr_r <= 1'b1; // [RULE16]
                gain_val_r <= hit_g5 ? GAIN_5V : (hit_g36 ? GAIN_3V6 : GAIN_2V5);
            end
            flip_r <= flip_r | hit_flip; // [RULE17]
            emi_r <= emi_r | hit_emi; // [RULE18]
            half_r <= half_r | hit_half; // [RULE19]
            sp32_r <= sp32_r | hit_32k;
        end
    end
    // The special 32 kHz mode only exists at 128x
    wire logic rate_sel = sp32_r | (strap_128x ^ flip_r);
    wire logic running = (state_r == ST_RUN) & sup_ok;

    // ==================== Decimator and three-level stage ====================
    logic [6:0] dec_cnt_r;
    logic [7:0] ones_r;
    logic pair_r;
    logic prev_r;
    wire logic [6:0] dec_last = rate_sel ? DEC128_LAST : DEC64_LAST; // [RULE9]
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dec_cnt_r <= 7'h00;
            ones_r <= 8'h00;
            pcm_sample <= 8'h00;
            pcm_valid <= 1'b0;
            {pair_r, prev_r, out_pos, out_neg} <= 4'h0;
        end else begin
            pcm_valid <= 1'b0;
            if (!running) begin
                dec_cnt_r <= 7'h00;
                ones_r <= 8'h00;
                {pair_r, out_pos, out_neg} <= 3'h0;
            end else if (take) begin
                pair_r <= ~pair_r;
                prev_r <= pdm_data_in_s;
                if (pair_r) begin
                    // Mixed pairs give no pulse, so an idle stream drives zero
                    out_pos <= prev_r & pdm_data_in_s & ~seen_r; // [RULE20] [RULE13]
                    out_neg <= ~prev_r & ~pdm_data_in_s & ~seen_r;
                end
                if (dec_cnt_r >= dec_last) begin
                    dec_cnt_r <= 7'h00;
                    ones_r <= 8'h00;
                    pcm_sample <= ones_r + {7'h00, pdm_data_in_s};
                    pcm_valid <= 1'b1;
                end else begin
                    dec_cnt_r <= dec_cnt_r + 7'h01;
                    ones_r <= ones_r + {7'h00, pdm_data_in_s};
                end
            end
            // A pulse must not outlive the mute that a pattern raises
            if (seen_r) begin
                out_pos <= 1'b0; // [RULE13]
                out_neg <= 1'b0;
            end
        end
    end

    // ==================== Status outputs ====================
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {amp_on, standby, full_pd} <= 3'b000;
            mute <= 1'b1;
            rate_128x <= 1'b0;
            gain_sel <= GAIN_5V;
            {low_emi, half_pulse, special_32k} <= 3'b000;
        end else begin
            amp_on <= running;
            standby <= state_r == ST_STANDBY;
            full_pd <= state_r == ST_FULL_PD;
            mute <= ~running | seen_r;
            rate_128x <= rate_sel;
            gain_sel <= gain_ovr_r ? gain_val_r : strap_gain;
            low_emi <= emi_r;
            half_pulse <= half_r;
            special_32k <= sp32_r;
        end
    end
endmodule : pdm_pattern_device

//--- verilog/pdm_pattern_source.sv
// Upstream PDM source: bit clock divider, audio byte and control patterns
`timescale 1ns/1ns
module pdm_pattern_source (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Command port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // PDM link
    pdm_if.src link
);
    import pdm_pkg::*;

    initial begin
        if (HALF_HI_CYC < 1 || HALF_LO_CYC > 255) begin
            $error("Bit clock divider out of range");
        end
        if (2 * SRC_LO_KHZ * HALF_LO_CYC != MCLK_KHZ || SRC_LO_KHZ > LO_BAND_MAX_KHZ
            || SRC_LO_KHZ < LO_BAND_MIN_KHZ || SRC_HI_KHZ > HI_BAND_MAX_KHZ
            || SRC_HI_KHZ < HI_BAND_MIN_KHZ) begin
            $error("Bit clock outside its band");
        end
    end

    localparam logic [7:0] HALF_LO = 8'(HALF_LO_CYC - 1);
    localparam logic [7:0] HALF_HI = 8'(HALF_HI_CYC - 1);
    localparam logic [7:0] REPS_LAST = 8'(PAT_MIN_REPS - 1);

    // ==================== Command registers ====================
    logic [7:0] ctrl_r;
    logic [7:0] audio_r;
    logic [7:0] pat_r;
    logic busy_r;
    logic [7:0] reps_r;
    logic [2:0] bit_r;
    logic [7:0] div_r;
    logic pclk_r;
    logic pdm_data_in_r;
    wire logic clk_en = ctrl_r[CTRL_CLK_EN];
    wire logic [7:0] half_last = ctrl_r[CTRL_HI_BAND] ? HALF_HI : HALF_LO; // [RULE1]
    wire logic wr_pat = wr & (addr == REG_PATTERN);
    wire logic [7:0] rd_mux = (addr == REG_CTRL) ? ctrl_r :
                              (addr == REG_AUDIO) ? audio_r :
                              (addr == REG_PATTERN) ? pat_r :
                              (addr == REG_STATUS) ? {6'h00, pclk_r, busy_r} : 8'h00;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RESET;
            audio_r <= AUDIO_RESET;
            pat_r <= PAT_STOP;
            rdata <= 8'h00;
        end else begin
            if (wr && addr == REG_CTRL) ctrl_r <= wdata;
            if (wr && addr == REG_AUDIO) audio_r <= wdata;
            if (wr_pat && !busy_r) pat_r <= wdata;
            rdata <= rd ? rd_mux : 8'h00;
        end
    end

    // ==================== Bit clock and data ====================
    wire logic half_done = clk_en & (div_r == half_last);
    // Data moves on the edge the device does not sample on
    wire logic shift = half_done & (ctrl_r[CTRL_RIGHT] ? ~pclk_r : pclk_r); // [RULE2] [RULE22]
    wire logic [7:0] cur_byte = busy_r ? pat_r : audio_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_r <= 8'h00;
            pclk_r <= 1'b0;
        end else if (!clk_en) begin
            div_r <= 8'h00;
            pclk_r <= 1'b0; // [RULE5]
        end else begin
            div_r <= half_done ? 8'h00 : div_r + 8'h01;
            pclk_r <= pclk_r ^ half_done;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
            reps_r <= 8'h00;
            bit_r <= 3'h0;
            pdm_data_in_r <= 1'b0;
        end else begin
            if (wr_pat && !busy_r) begin
                busy_r <= 1'b1;
                // A write lands mid-byte: the partial first byte is not a repeat
                reps_r <= 8'hff;
            end else if (shift && bit_r == 3'h7 && busy_r) begin
                busy_r <= reps_r != REPS_LAST; // [RULE12]
                reps_r <= reps_r + 8'h01;
            end
            if (shift) begin
                pdm_data_in_r <= cur_byte[3'h7 - bit_r];
                bit_r <= bit_r + 3'h1;
            end
        end
    end
    assign link.pdm_clk = pclk_r;
    assign link.pdm_data_in = pdm_data_in_r;
endmodule : pdm_pattern_source

//--- verification/pdm_link_sva.sv
// Checker for the PDM link and the front end status outputs
`timescale 1ns/1ns
module pdm_link_sva import pdm_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Link and supervisor levels
    input wire logic pdm_clk,
    input wire logic pdm_data_in,
    input wire logic power_stage_supply,
    input wire logic logic_supply,
    input wire logic smart_pd_en,
    // Device status
    input wire logic amp_on,
    input wire logic standby,
    input wire logic full_pd,
    input wire logic mute,
    input wire logic rate_128x,
    input wire logic special_32k,
    input wire logic out_pos,
    input wire logic out_neg
);
    // ==================== Bit clock quiet time ====================
    // Margin covers the input synchroniser ahead of the loss timer
    localparam int LOSS_LIMIT = CLK_LOSS_CYC + 20;
    logic clk_prev_r;
    logic [10:0] quiet_r;
    logic [10:0] quiet_nxt;
    assign quiet_nxt = (pdm_clk != clk_prev_r) ? 11'h000 :
        ((quiet_r == 11'h7ff) ? quiet_r : quiet_r + 11'h001);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            clk_prev_r <= 1'b0;
            quiet_r <= 11'h000;
        end else begin
            clk_prev_r <= pdm_clk;
            quiet_r <= quiet_nxt;
        end
    end
    // ==================== Properties ====================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_enter_pd;
        standby ##1 full_pd;
    endsequence
    AST_THREE_LEVEL: assert property (!(out_pos && out_neg))
        else $error("both outputs driven high");
    AST_MUTE_SILENT: assert property (mute [*2] |-> !out_pos && !out_neg)
        else $error("output pulses while muted");
    AST_STANDBY_MUTED: assert property (standby |-> mute && !full_pd)
        else $error("standby without mute");
    AST_STANDBY_LOSS: assert property (standby |-> quiet_r < LOSS_LIMIT)
        else $error("standby kept after clock loss");
    AST_PD_HOLD: assert property (s_enter_pd |-> !amp_on [*8])
        else $error("amplifier on right after power-down");
    AST_RUN_LOSS: assert property (amp_on && smart_pd_en |-> quiet_r < LOSS_LIMIT)
        else $error("running with no bit clock");
    AST_SUPPLY_OFF: assert property (!power_stage_supply || !logic_supply |-> ##[0:5] !amp_on)
        else $error("amplifier on with supply low");
    AST_DATA_ON_LOW: assert property ($changed(pdm_data_in) |-> !pdm_clk)
        else $error("data moved while clock high");
    AST_SPECIAL_RATE: assert property (special_32k |-> rate_128x)
        else $error("special mode without 128x rate");
endmodule : pdm_link_sva

//--- verification/pdm_input_pattern_control_tb_top.sv
// Testbench joining the PDM source and the amplifier front end
`timescale 1ns/1ns
module pdm_input_pattern_control_tb_top;
    import pdm_pkg::*;
    // ==================== Signals and instances ====================
    localparam int BIT_CYC = 2 * HALF_HI_CYC;
    logic mclk, rst_b, wr, rd, power_stage_supply, logic_supply;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pcm_sample, d;
    logic [1:0] gain_rate_strap;
    logic amp_on, standby, full_pd, mute, rate_128x, low_emi, half_pulse, special_32k;
    logic pcm_valid, out_pos, out_neg;
    gain_t gain_sel;
    int n_fail, n_checks, cyc;
    pdm_if link ();
    pdm_pattern_source pdm_pattern_source_i (.mclk(mclk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
    pdm_pattern_device #(.STARTUP_CYCLES(20)) pdm_pattern_device_i (.mclk(mclk),
        .rst_b(rst_b), .link(link), .gain_rate_strap(gain_rate_strap), .channel_select(1'b0),
        .power_stage_supply(power_stage_supply), .logic_supply(logic_supply),
        .smart_pd_en(1'b1), .amp_on(amp_on), .standby(standby), .full_pd(full_pd),
        .mute(mute), .rate_128x(rate_128x), .gain_sel(gain_sel), .low_emi(low_emi),
        .half_pulse(half_pulse), .special_32k(special_32k), .pcm_sample(pcm_sample),
        .pcm_valid(pcm_valid), .out_pos(out_pos), .out_neg(out_neg));
    pdm_link_sva pdm_link_sva_i (.mclk(mclk), .rst_b(rst_b), .pdm_clk(link.pdm_clk),
        .pdm_data_in(link.pdm_data_in), .power_stage_supply(power_stage_supply),
        .logic_supply(logic_supply), .smart_pd_en(1'b1), .amp_on(amp_on),
        .standby(standby), .full_pd(full_pd), .mute(mute), .rate_128x(rate_128x),
        .special_32k(special_32k), .out_pos(out_pos), .out_neg(out_neg));
    // ==================== Shared tasks ====================
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    task automatic wait_hi(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(posedge mclk);
        #1;
    endtask : wait_hi
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // ==================== Scenarios ====================
    task automatic t_regs();
        rd_reg(REG_CTRL, d);
        check(d === CTRL_RESET, "control reset value");
        rd_reg(REG_AUDIO, d);
        check(d === AUDIO_RESET, "audio reset value");
        wr_reg(REG_CTRL, 8'h03);
        wr_reg(REG_AUDIO, 8'h0b);
        wr_reg(4'h2, 8'h5a);
        rd_reg(4'h2, d);
        check(d === 8'h00, "unmapped read not zero");
        rd_reg(REG_AUDIO, d);
        check(d === 8'h0b, "audio readback");
        rd_reg(REG_STATUS, d);
        check(d[0] === 1'b0, "busy while idle");
        $display("test regs done");
    endtask : t_regs
    task automatic t_strap();
        wait_hi(amp_on, 200);
        check(rate_128x === 1'b0 && gain_sel === GAIN_5V, "strap decode 64x 5V");
        gain_rate_strap <= 2'b01;
        repeat (20) @(posedge mclk);
        check(rate_128x === 1'b0, "strap taken again while running");
        power_stage_supply <= 1'b0;
        repeat (10) @(posedge mclk);
        check(amp_on === 1'b0 && mute === 1'b1, "running with supply low");
        power_stage_supply <= 1'b1;
        wait_hi(amp_on, 200);
        check(amp_on === 1'b1 && rate_128x === 1'b1, "strap decode 128x");
        $display("test strap done");
    endtask : t_strap
    // A byte sent MSB first sits whole in some window of 16 taken bits
    task automatic t_wire();
        logic [15:0] sh;
        logic hit;
        sh = 16'h0000;
        hit = 1'b0;
        repeat (16) @(posedge link.pdm_clk) sh = {sh[14:0], link.pdm_data_in};
        for (int k = 0; k < 9; k++) if (sh[k+:8] == 8'h0b) hit = 1'b1;
        check(hit, "bit order on the data line");
        for (int i = 0; i < 6000 && pcm_valid !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        check(pcm_valid === 1'b1 && pcm_sample === 8'(DECIM_128 / 8 * 3), "decimated count");
        $display("test wire done");
    endtask : t_wire
    task automatic t_gain();
        wr_reg(REG_PATTERN, PAT_GAIN_3V6);
        repeat (64 * PAT_BITS * BIT_CYC) @(posedge mclk);
        check(mute === 1'b1, "no mute during pattern");
        check(gain_sel === GAIN_5V, "gain acted before full count");
        for (int i = 0; i < 15000; i++) begin
            rd_reg(REG_STATUS, d);
            if (d[0] === 1'b0) break;
        end
        repeat (3 * BIT_CYC) @(posedge mclk);
        check(gain_sel === GAIN_3V6, "gain pattern ignored");
        repeat (32 * BIT_CYC) @(posedge mclk);
        check(mute === 1'b0, "mute kept after pattern ended");
        $display("test gain done");
    endtask : t_gain
    task automatic t_stop();
        wr_reg(REG_AUDIO, PAT_STOP);
        wait_hi(standby, 1100 * PAT_BITS * BIT_CYC);
        check(standby === 1'b1 && amp_on === 1'b0, "stop byte gave no standby");
        wr_reg(REG_CTRL, 8'h00);
        wait_hi(full_pd, 1000);
        check(full_pd === 1'b1, "no power-down on clock loss");
        check(gain_sel === GAIN_5V, "gain not reverted");
        wr_reg(REG_AUDIO, 8'h0b);
        wr_reg(REG_CTRL, 8'h03);
        wait_hi(amp_on, 3000);
        check(amp_on === 1'b1 && full_pd === 1'b0, "no resume");
        $display("test stop done");
    endtask : t_stop
    // ==================== Clock, timeout and main sequence ====================
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Two full patterns and one decimation window take about 91000 cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 98000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        gain_rate_strap = 2'b11;
        power_stage_supply = 1'b1;
        logic_supply = 1'b1;
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_strap();
        t_wire();
        t_gain();
        t_stop();
        close_out();
    end
endmodule : pdm_input_pattern_control_tb_top
